//--- design/dbsp_pkg.sv
// Shared constants and carriers for the burst SRAM port model.
// Assumes one system clock that samples the memory pins synchronously.
`default_nettype none
package dbsp_pkg;
  localparam int WORD_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES  = 4;
  localparam int ADDR_W = 21;
  localparam logic [WORD_W-1:0] Q_RST    = 36'h0;
  localparam logic [LANES-1:0]  MASK_ALL = 4'hF;
  localparam logic [LANES-1:0]  MASK_NONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 21'h1;

  // One pending read slot in the latency pipeline
  typedef struct packed {
    logic              vld;
    logic [ADDR_W-1:0] addr;
  } dbsp_slot_s;

  localparam dbsp_slot_s SLOT_RST = '{vld: 1'b0, addr: 21'h0};
endpackage
`default_nettype wire

//--- design/dbsp_mem.sv
// Word array with per-lane write enables and a registered read port.
// Assumes write and read never need the same cycle's data; caller orders them.
`default_nettype none
module dbsp_mem #(
  parameter int ADDR_W = dbsp_pkg::ADDR_W,
  parameter int WORD_W = dbsp_pkg::WORD_W,
  parameter int LANE_W = dbsp_pkg::LANE_W,
  parameter int LANES  = dbsp_pkg::LANES
) (
  // Clock
  input  wire logic              clk_sys,
  // Write port
  input  wire logic [LANES-1:0]  we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WORD_W-1:0] wdata,
  // Read port
  input  wire logic              re,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WORD_W-1:0] rdata_q
);
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  // One process owns the array; lanes are enabled one by one inside it
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LANES; i++) begin
      if (we[i]) begin
        mem[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (re) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

//--- design/dbsp_port.sv
// Synchronous two-word burst port: input clock edges, selects, byte masks,
// read latency pipeline and tristate control of the read data pins.
// Assumes k_pos/k_neg are slow versus clk_sys: at least 3 cycles between edges.
//
// Operation
// R1: Write starts on select low at positive rise; words on that and next negative rise.
// R2: Read select low latches address; words return two positive rises later, then negative.
// R3: After reset both ports idle and read data pins tristated.
// R4: Controller should park stopped clocks high; advice only.
// R5: All byte selects low on a beat writes the whole word.
// R6: Each byte select gates its own 9-bit lane; deselected lanes keep contents.
// R7: All byte selects high on a beat leaves the word unchanged.
// R8: Byte selects are sampled per beat; masks may differ between words.
// R9: First beat uses address A, second beat uses A plus one.
// R10: Write data taken and read data launched on rises of both clocks.
// R11: With clocks stopped, pins hold previous state and nothing starts.
// R12: Read deselected with nothing pending: write data ignored, outputs tristated; code still writes if write select is low.
// R13: Latency pin high gives two-cycle reads; low gives one-cycle reads.
// R14: After deselect, pending reads finish, then outputs tristate after next positive rise.
// R15: Read of a just-written location returns the newest data.
`default_nettype none
module dbsp_port (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  // Input clock pair, sampled as levels
  input  wire logic                            k_pos,
  input  wire logic                            k_neg,
  // Command and write data
  input  wire logic                            read_port_select_n,
  input  wire logic                            write_port_select_n,
  input  wire logic [dbsp_pkg::ADDR_W-1:0]     addr,
  input  wire logic [dbsp_pkg::WORD_W-1:0]     data_in,
  input  wire logic [dbsp_pkg::LANES-1:0]      byte_write_select_n,
  input  wire logic                            latency_mode_pin,
  // Read data pins
  output logic      [dbsp_pkg::WORD_W-1:0]     q_data,
  output logic                                 q_oe_n
);
  ////////////////////////////////////////////////////////////////////////////
  logic                          k_pos_q, k_neg_q;
  logic                          pos_rise_q, neg_rise_q;
  logic                          wr_pend_q;
  logic [dbsp_pkg::ADDR_W-1:0]   wr_addr_q;
  dbsp_pkg::dbsp_slot_s          slot1_q, slot2_q;
  logic                          beat1_q;
  logic [dbsp_pkg::WORD_W-1:0]   word0_q, word1_q, rdata_q;
  logic                          fetch0_q, fetch1_q;
  logic [dbsp_pkg::WORD_W-1:0]   q_data_q;
  logic                          q_oe_n_q;

  // Edge events; no edge means stopped clocks, so nothing moves
  wire pos_rise = k_pos & ~k_pos_q;  // see R10 see R11
  wire neg_rise = k_neg & ~k_neg_q;  // see R10 see R11

  ////////////////////////////////////////////////////////////////////////////
  // Write path: beat 0 on positive rise, beat 1 on following negative rise
  wire                         wr_beat0 = pos_rise & ~write_port_select_n;  // see R1
  wire                         wr_beat1 = neg_rise & wr_pend_q;             // see R1
  wire [dbsp_pkg::LANES-1:0]   lane_en  = ~byte_write_select_n;             // see R6 see R8
  wire [dbsp_pkg::LANES-1:0]   mem_we   = (wr_beat0 | wr_beat1) ? lane_en
                                                                  : dbsp_pkg::MASK_NONE;
  wire [dbsp_pkg::ADDR_W-1:0]  mem_waddr = wr_beat1 ? wr_addr_q + dbsp_pkg::ADDR_ONE
                                                    : addr;  // see R9

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      k_pos_q   <= 1'b1;
      k_neg_q   <= 1'b1;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      k_pos_q <= k_pos;
      k_neg_q <= k_neg;
      if (wr_beat0) begin
        wr_pend_q <= 1'b1;
        wr_addr_q <= addr;
      end else if (wr_beat1) begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pipeline: slot1 = started last rise, slot2 = one rise older
  wire                  lat2 = latency_mode_pin;                   // see R13
  dbsp_pkg::dbsp_slot_s new_slot;
  assign new_slot.vld  = ~read_port_select_n;                      // see R2
  assign new_slot.addr = addr;
  wire dbsp_pkg::dbsp_slot_s due = lat2 ? slot2_q : slot1_q;       // see R13

  // Fetch one cycle after the edge, so a beat written on that edge is seen
  // Slots have shifted by then, so due names the burst for the coming rise;
  // a write started on the output rise itself is not forwarded
  wire                         mem_re    = pos_rise_q | neg_rise_q;  // see R15
  wire [dbsp_pkg::ADDR_W-1:0]  mem_raddr = neg_rise_q ? due.addr + dbsp_pkg::ADDR_ONE
                                                      : due.addr;    // see R9

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slot1_q    <= dbsp_pkg::SLOT_RST;
      slot2_q    <= dbsp_pkg::SLOT_RST;
      pos_rise_q <= 1'b0;
      neg_rise_q <= 1'b0;
      fetch0_q   <= 1'b0;
      fetch1_q   <= 1'b0;
    end else begin
      pos_rise_q <= pos_rise;
      neg_rise_q <= neg_rise;
      fetch0_q   <= pos_rise_q;
      fetch1_q   <= neg_rise_q;
      if (pos_rise) begin
        slot1_q <= new_slot;
        slot2_q <= slot1_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fetch0_q) begin
      word0_q <= rdata_q;
    end
    if (fetch1_q) begin
      word1_q <= rdata_q;
    end
  end

  dbsp_mem u_mem (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (data_in),
    .re      (mem_re),
    .raddr   (mem_raddr),
    .rdata_q (rdata_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output launch; drive only while a burst is due, else float
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_data_q <= dbsp_pkg::Q_RST;  // see R3
      q_oe_n_q <= 1'b1;             // see R3
      beat1_q  <= 1'b0;
    end else if (pos_rise) begin
      beat1_q  <= due.vld;
      q_oe_n_q <= ~due.vld;         // see R2 see R12 see R14
      if (due.vld) begin
        q_data_q <= word0_q;        // see R10
      end
    end else if (neg_rise && beat1_q) begin
      q_data_q <= word1_q;          // see R10
      beat1_q  <= 1'b0;
    end
  end

  assign q_data = q_data_q;
  assign q_oe_n = q_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_write_pending: assert property (wr_beat0 |=> wr_pend_q) // see R1
    else $error("write start did not arm second beat");
  a_read_lat2: assert property (
    pos_rise && lat2 && slot2_q.vld |=> !q_oe_n_q) // see R2
    else $error("two-cycle read did not drive");
  a_reset_float: assert property (@(posedge clk_sys) disable iff (1'b0) rst |=> q_oe_n_q) // see R3
    else $error("outputs driven after reset");
  a_full_word: assert property (
    (wr_beat0 || wr_beat1) && byte_write_select_n == dbsp_pkg::MASK_NONE
    |-> mem_we == dbsp_pkg::MASK_ALL) // see R5
    else $error("full word not written");
  a_lane_mask: assert property (
    (wr_beat0 || wr_beat1) |-> mem_we == ~byte_write_select_n) // see R6 see R8
    else $error("lane enables differ from byte selects");
  a_masked_beat: assert property (
    byte_write_select_n == dbsp_pkg::MASK_ALL |-> mem_we == dbsp_pkg::MASK_NONE) // see R7
    else $error("write with all lanes deselected");
  a_beat1_addr: assert property (
    wr_beat1 |-> mem_waddr == wr_addr_q + dbsp_pkg::ADDR_ONE) // see R9
    else $error("second beat address not A plus one");
  a_idle_hold: assert property (
    !pos_rise && !neg_rise |=> $stable(q_data_q) && $stable(q_oe_n_q)) // see R10 see R11
    else $error("outputs moved without a clock edge");
  a_no_write_idle: assert property (
    !wr_beat0 && !wr_beat1 |-> mem_we == dbsp_pkg::MASK_NONE) // see R12
    else $error("write without a started write");
  a_read_lat1: assert property (
    pos_rise && !lat2 && slot1_q.vld |=> !q_oe_n_q) // see R13
    else $error("one-cycle read did not drive");
  a_tristate_after: assert property (
    pos_rise && !due.vld |=> q_oe_n_q) // see R14
    else $error("outputs not floated after read drain");
  a_word0_launch: assert property ( // see R2 see R10
    pos_rise && due.vld |=> q_data_q == $past(word0_q))
    else $error("first read word not launched");
  a_word1_launch: assert property ( // see R9 see R10
    neg_rise && beat1_q && !pos_rise |=> q_data_q == $past(word1_q))
    else $error("second read word not launched");
  a_pend_clears: assert property ( // see R1
    wr_beat1 && !wr_beat0 |=> !wr_pend_q)
    else $error("second write beat did not close the burst");
  a_slot_hold: assert property ( // see R11
    !pos_rise |=> $stable(slot1_q) && $stable(slot2_q))
    else $error("read pipeline moved without a positive rise");
  a_slot_load: assert property ( // see R2 see R9
    pos_rise |=> slot1_q.vld == !$past(read_port_select_n) && slot1_q.addr == $past(addr))
    else $error("read start not latched");
  a_neg_no_pend: assert property ( // see R1 see R12
    neg_rise && !wr_pend_q && !wr_beat0 |-> mem_we == dbsp_pkg::MASK_NONE)
    else $error("negative rise wrote with no write pending");
  a_float_quiet: assert property ( // see R12 see R14
    q_oe_n_q && !pos_rise |=> q_oe_n_q)
    else $error("read pins driven between positive rises");

  c_write_burst: cover property (wr_beat0 ##[1:20] wr_beat1);
  c_read_burst: cover property (pos_rise && due.vld ##[1:20] neg_rise && beat1_q);
  c_masked_write: cover property (wr_beat1 && mem_we != dbsp_pkg::MASK_ALL);
  c_read_lat1: cover property (pos_rise && !lat2 && slot1_q.vld);
  c_clock_stop: cover property ((!pos_rise && !neg_rise) [*8]);
endmodule
`default_nettype wire

//--- verification/dbsp_ctrl_model.sv
// Controller model: makes the input clock pair and one command per cycle.
// Assumes the bench calls its tasks one at a time from a single process.
`default_nettype none
module dbsp_ctrl_model (
  // Clock
  input  wire logic                        clk_sys,
  // Towards the port
  output logic                             k_pos,
  output logic                             k_neg,
  output logic                             read_port_select_n,
  output logic                             write_port_select_n,
  output logic [dbsp_pkg::ADDR_W-1:0]      addr,
  output logic [dbsp_pkg::WORD_W-1:0]      data_in,
  output logic [dbsp_pkg::LANES-1:0]       byte_write_select_n,
  // From the port
  input  wire logic [dbsp_pkg::WORD_W-1:0] q_data,
  input  wire logic                        q_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;
  initial begin
    k_pos = 1'b1;  // Parked high for a quick restart
    k_neg = 1'b1;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addr = 21'h0;
    data_in = 36'h0;
    byte_write_select_n = 4'hF;
  end
  ////////////////////////////////////////
  // Low half first, so the next k_pos change is a rise
  task automatic resume();
    @(posedge clk_sys);
    k_pos <= 1'b0;
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    repeat (HALF - 1) @(posedge clk_sys);
  endtask
  // Beat data at both rises, unused data lines flip
  task automatic kcyc(input logic rps_n, input logic wps_n, input logic [20:0] a,
                      input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] m0,
                      input logic [3:0] m1, output logic [35:0] q0, output logic [35:0] q1,
                      output logic oe0);
    @(posedge clk_sys);
    k_pos <= 1'b1;
    k_neg <= 1'b0;
    read_port_select_n <= rps_n;
    write_port_select_n <= wps_n;
    addr <= a;
    data_in <= wps_n ? ~data_in : d0;
    byte_write_select_n <= m0;
    repeat (HALF - 1) @(posedge clk_sys);
    #1;
    q0 = q_data;
    oe0 = q_oe_n;
    @(posedge clk_sys);
    k_pos <= 1'b0;
    k_neg <= 1'b1;
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= ~addr;
    data_in <= wps_n ? ~data_in : d1;
    byte_write_select_n <= m1;
    repeat (HALF - 1) @(posedge clk_sys);
    #1;
    q1 = q_data;
  endtask
  // Stop high with selects low and inputs moving
  task automatic park(input int n, output logic [36:0] qa, output logic [36:0] qb);
    @(posedge clk_sys);
    k_pos <= 1'b1;
    k_neg <= 1'b0;
    repeat (HALF) @(posedge clk_sys);
    k_neg <= 1'b1;
    repeat (HALF) @(posedge clk_sys);
    #1;
    qa = {q_oe_n, q_data};
    repeat (n) begin
      @(posedge clk_sys);
      read_port_select_n <= 1'b0;
      write_port_select_n <= 1'b0;
      addr <= ~addr;
      data_in <= ~data_in;
    end
    #1;
    qb = {q_oe_n, q_data};
  endtask
endmodule
`default_nettype wire

//--- verification/test_ddr_burst_sram_port.sv
// Bench for the burst SRAM port: scenario tasks over the controller model.
// Assumes the model drives every port input but clk_sys, reset and latency mode.
`default_nettype none
module test_ddr_burst_sram_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 latency_mode_pin = 1'b1;
  logic                 k_pos, k_neg, read_port_select_n, write_port_select_n, q_oe_n;
  logic [20:0]          addr;
  logic [35:0]          data_in, q_data, q0, q1;
  logic [3:0]           byte_write_select_n;
  logic                 oe0;
  logic [36:0]          qa, qb;
  int                   err_count = 0;
  int                   n_tests = 0;
  logic [35:0]          mem_m [logic [20:0]];
  dbsp_pkg::dbsp_slot_s h1 = dbsp_pkg::SLOT_RST;
  dbsp_pkg::dbsp_slot_s h2 = dbsp_pkg::SLOT_RST;
  dbsp_port u_dbsp_port (.clk_sys, .rst, .k_pos, .k_neg, .read_port_select_n,
    .write_port_select_n, .addr, .data_in, .byte_write_select_n, .latency_mode_pin,
    .q_data, .q_oe_n);
  dbsp_ctrl_model u_dbsp_ctrl_model (.clk_sys, .k_pos, .k_neg, .read_port_select_n,
    .write_port_select_n, .addr, .data_in, .byte_write_select_n, .q_data, .q_oe_n);
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [36:0] seen, input logic [36:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d,
                                        input logic [3:0] m_n);
    for (int i = 0; i < 4; i++) begin
      if (!m_n[i]) o[i*9 +: 9] = d[i*9 +: 9];
    end
    return o;
  endfunction
  // One K cycle; reads judged before this cycle's write lands in the shadow
  task automatic burst(input logic rps_n, input logic wps_n, input logic [20:0] a,
                       input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] m0,
                       input logic [3:0] m1);
    dbsp_pkg::dbsp_slot_s due;
    due = latency_mode_pin ? h2 : h1;
    u_dbsp_ctrl_model.kcyc(rps_n, wps_n, a, d0, d1, m0, m1, q0, q1, oe0);
    if (due.vld) begin
      check("read drive", oe0, 1'b0);
      check("read word A", q0, mem_m[due.addr]);
      check("read word A+1", q1, mem_m[due.addr + 21'h1]);
    end else begin
      check("read float", oe0, 1'b1);
    end
    if (!wps_n) begin
      mem_m[a] = merge(mem_m[a], d0, m0);
      mem_m[a + 21'h1] = merge(mem_m[a + 21'h1], d1, m1);
    end
    h2 = h1;
    h1 = '{vld: !rps_n, addr: a};
  endtask
  task automatic rd(input logic [20:0] a);
    burst(1'b0, 1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
  endtask
  task automatic idle();
    burst(1'b1, 1'b1, 21'h0, 36'h0, 36'h0, 4'hF, 4'hF);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    check("float after reset", q_oe_n, 1'b1);
    u_dbsp_ctrl_model.resume();
    idle();
  endtask
  task automatic t_full();
    burst(1'b1, 1'b0, 21'h10, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
    rd(21'h10);
    idle();
    idle();
  endtask
  // Masks differ per beat; last pass has every select high
  task automatic t_lanes();
    for (int i = 0; i <= 4; i++) begin
      burst(1'b1, 1'b0, 21'h10, 36'h5A5A5A5A5 - i, 36'h0F0F0F0F0 + i, ~(4'h1 << i),
            ~(4'h8 >> i));
      rd(21'h10);
    end
    idle();
    idle();
  endtask
  task automatic t_lat1();
    @(posedge clk_sys);
    latency_mode_pin <= 1'b0;
    @(posedge clk_sys);
    rd(21'h10);
    burst(1'b1, 1'b0, 21'h30, 36'hC3C3C3C3C, 36'h3C3C3C3C3, 4'h0, 4'h0);
    rd(21'h30);
    idle();
    idle();
    @(posedge clk_sys);
    latency_mode_pin <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic t_stop();
    rd(21'h30);
    idle();
    u_dbsp_ctrl_model.park(40, qa, qb);
    check("stopped drive", qa, {1'b0, mem_m[21'h31]});
    check("stopped hold", qb, qa);
    h2 = h1;
    h1 = dbsp_pkg::SLOT_RST;
    u_dbsp_ctrl_model.resume();
    idle();
    idle();
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_full();
    t_lanes();
    t_lat1();
    t_stop();
    close_out();
  end
  initial begin
    #20us;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
